// File: ibm_ctrl.sv
// Purpose: IDE programming-interface byte, drive decode and bus master channels
// Assumes: I/O and configuration strobes are one-cycle and synchronous to mclk
// Notes:   Drive data moves through one buffer per channel toward memory
`timescale 1ns/1ps
module ibm_ctrl #(
  parameter int        DWIDTH   = ibm_pkg::FIFO_WIDTH,
  parameter int        DEPTH    = ibm_pkg::FIFO_DEPTH,
  parameter logic      BM_CAP   = 1'b1,
  parameter logic      PRI_NATV = 1'b1,
  parameter logic      SEC_NATV = 1'b1
) (
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic              ce,
  input  wire logic              cfg_wr,
  input  wire logic              cfg_rd,
  input  wire logic [7:0]        cfg_addr,
  input  wire logic [3:0]        cfg_be,
  input  wire logic [31:0]       cfg_wdata,
  output logic      [31:0]       cfg_rdata_ff,
  input  wire logic              io_wr,
  input  wire logic              io_rd,
  input  wire logic [15:0]       io_addr,
  input  wire logic [3:0]        io_be,
  input  wire logic [31:0]       io_wdata,
  output logic      [31:0]       io_rdata_ff,
  output logic                   io_hit_ff,
  output logic      [1:0]        drv_sel_ff,
  output logic      [1:0]        drv_ctl_sel_ff,
  input  wire logic [1:0]        drv_irq,
  input  wire logic [1:0]        drv_done,
  input  wire logic [1:0]        mem_err,
  input  wire logic [1:0]        drv_valid,
  output logic      [1:0]        drv_ready_ff,
  input  wire logic [2*DWIDTH-1:0] drv_data,
  output logic      [1:0]        mem_valid_ff,
  input  wire logic [1:0]        mem_ready,
  output logic      [2*DWIDTH-1:0] mem_data_ff,
  output logic      [1:0]        bm_dir_ff,
  output logic      [1:0]        bm_run_ff,
  output logic      [1:0]        bm_abort_ff,
  output logic      [63:0]       table_ptr_ff
);
  logic [7:0]  prog_if_ff;
  logic [31:0] pri_cbase_ff;
  logic [31:0] pri_ctrl_ff;
  logic [31:0] sec_cbase_ff;
  logic [31:0] sec_ctrl_ff;
  logic [31:0] bm_base_ff;
  logic [1:0]  chan_en;
  logic [1:0]  natv;
  logic [1:0]  cmd_hit;
  logic [1:0]  ctl_hit;
  logic        bm_hit;
  logic [3:0]  bm_ofs;
  logic [31:0] bm_word [2];
  logic [31:0] nxt_io_rdata;
  logic [31:0] nxt_cfg_rdata;

  assign chan_en = {prog_if_ff[ibm_pkg::PI_SEN_BIT], prog_if_ff[ibm_pkg::PI_PEN_BIT]};
  assign natv    = {prog_if_ff[ibm_pkg::PI_SNAT_BIT], prog_if_ff[ibm_pkg::PI_PNAT_BIT]};
  assign bm_hit  = (io_addr[15:4] == bm_base_ff[15:4]);
  assign bm_ofs  = io_addr[3:0];

  // Drive ranges per channel
  always_comb begin
    cmd_hit[0] = natv[0] ? (io_addr[15:3] == pri_cbase_ff[15:3])
                         : (io_addr[15:3] == ibm_pkg::PRI_CMD_LO[15:3]);
    ctl_hit[0] = natv[0] ? (io_addr == {pri_ctrl_ff[15:2], 2'b10})
                         : (io_addr == ibm_pkg::PRI_CTL_ADR);
    cmd_hit[1] = natv[1] ? (io_addr[15:3] == sec_cbase_ff[15:3])
                         : (io_addr[15:3] == ibm_pkg::SEC_CMD_LO[15:3]);
    ctl_hit[1] = natv[1] ? (io_addr == {sec_ctrl_ff[15:2], 2'b10})
                         : (io_addr == ibm_pkg::SEC_CTL_ADR);
    cmd_hit = cmd_hit & chan_en;
    ctl_hit = ctl_hit & chan_en;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      drv_sel_ff     <= 2'h0;
      drv_ctl_sel_ff <= 2'h0;
      io_hit_ff      <= 1'b0;
    end else if (ce) begin
      drv_sel_ff     <= (io_wr || io_rd) ? cmd_hit : 2'h0;
      drv_ctl_sel_ff <= (io_wr || io_rd) ? ctl_hit : 2'h0;
      io_hit_ff      <= (io_wr || io_rd) && (bm_hit || (|cmd_hit) || (|ctl_hit));
    end
  end

  // Configuration space: prog-if and base registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      prog_if_ff   <= ibm_pkg::PROG_IF_RESET;
      pri_cbase_ff <= 32'h1;
      pri_ctrl_ff  <= 32'h1;
      sec_cbase_ff <= 32'h1;
      sec_ctrl_ff  <= 32'h1;
      bm_base_ff   <= 32'h1;
    end else if (ce && cfg_wr) begin
      if (cfg_addr[7:2] == ibm_pkg::CFG_PROG_IF[7:2] && cfg_be[1]) begin
        prog_if_ff[ibm_pkg::PI_PEN_BIT]  <= cfg_wdata[8+ibm_pkg::PI_PEN_BIT];
        prog_if_ff[ibm_pkg::PI_SEN_BIT]  <= cfg_wdata[8+ibm_pkg::PI_SEN_BIT];
        prog_if_ff[ibm_pkg::PI_SNAT_BIT] <= SEC_NATV & cfg_wdata[8+ibm_pkg::PI_SNAT_BIT];
        prog_if_ff[ibm_pkg::PI_PNAT_BIT] <= PRI_NATV & cfg_wdata[8+ibm_pkg::PI_PNAT_BIT];
      end
      case (cfg_addr[7:2])
        ibm_pkg::CFG_PRI_CBASE[7:2]: pri_cbase_ff <= {cfg_wdata[31:3], 3'h1};
        ibm_pkg::CFG_PRI_CTRL[7:2]:  pri_ctrl_ff  <= {cfg_wdata[31:2], 2'h1};
        ibm_pkg::CFG_SEC_CBASE[7:2]: sec_cbase_ff <= {cfg_wdata[31:3], 3'h1};
        ibm_pkg::CFG_SEC_CTRL[7:2]:  sec_ctrl_ff  <= {cfg_wdata[31:2], 2'h1};
        ibm_pkg::CFG_BM_BASE[7:2]:   bm_base_ff   <= {cfg_wdata[31:4], 4'h1};
        default: ;
      endcase
    end
  end

  always_comb begin
    nxt_cfg_rdata = 32'h0;
    case (cfg_addr[7:2])
      ibm_pkg::CFG_PROG_IF[7:2]: begin
        nxt_cfg_rdata[15:8] = prog_if_ff;
        nxt_cfg_rdata[8+ibm_pkg::PI_BM_BIT]  = BM_CAP;
        nxt_cfg_rdata[8+ibm_pkg::PI_RPT_BIT] = 1'b0;
        nxt_cfg_rdata[8+3] = SEC_NATV;
        nxt_cfg_rdata[8+1] = PRI_NATV;
      end
      ibm_pkg::CFG_PRI_CBASE[7:2]: nxt_cfg_rdata = pri_cbase_ff;
      ibm_pkg::CFG_PRI_CTRL[7:2]:  nxt_cfg_rdata = pri_ctrl_ff;
      ibm_pkg::CFG_SEC_CBASE[7:2]: nxt_cfg_rdata = sec_cbase_ff;
      ibm_pkg::CFG_SEC_CTRL[7:2]:  nxt_cfg_rdata = sec_ctrl_ff;
      ibm_pkg::CFG_BM_BASE[7:2]:   nxt_cfg_rdata = bm_base_ff;
      default:                     nxt_cfg_rdata = 32'h0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      cfg_rdata_ff <= 32'h0;
    end else if (ce && cfg_rd) begin
      cfg_rdata_ff <= nxt_cfg_rdata;
    end
  end

  // Per-channel bus master logic
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_ch
      localparam logic [3:0] CMD_OFS = (ch == 0) ? ibm_pkg::OFS_PRI_CMD : ibm_pkg::OFS_SEC_CMD;
      localparam logic [3:0] PTR_OFS = (ch == 0) ? ibm_pkg::OFS_PRI_PTR : ibm_pkg::OFS_SEC_PTR;
      logic [7:0]          cmd_ff;
      logic [7:0]          stat_ff;
      logic [31:0]         ptr_ff;
      logic                irq_d_ff;
      ibm_pkg::ibm_state_t st_ff;
      ibm_pkg::ibm_state_t nxt_st;
      logic                wr_lo;
      logic                wr_st;
      logic                new_start;
      logic                start_up;
      logic                stop;
      logic                f_in_rdy;
      logic                f_out_vld;
      logic [DWIDTH-1:0]   f_out_data;

      // Command byte at CMD_OFS (lane 0), status at +2 (lane 2) of same word
      assign wr_lo     = ce && io_wr && bm_hit && (bm_ofs[3:2] == CMD_OFS[3:2]);
      assign wr_st     = wr_lo && io_be[2];
      assign new_start = io_wdata[ibm_pkg::CMD_START_BIT];
      assign start_up  = wr_lo && io_be[0] && new_start && !cmd_ff[ibm_pkg::CMD_START_BIT];
      assign stop      = wr_lo && io_be[0] && !new_start && cmd_ff[ibm_pkg::CMD_START_BIT];

      always_ff @(posedge mclk) begin
        if (rst) begin
          cmd_ff <= ibm_pkg::CMD_RESET;
        end else if (wr_lo && io_be[0]) begin
          cmd_ff <= {4'h0, io_wdata[3], 2'h0, io_wdata[0]};
        end
      end

      always_ff @(posedge mclk) begin
        if (rst) begin
          ptr_ff <= 32'h0;
        end else if (ce && io_wr && bm_hit && bm_ofs[3:2] == PTR_OFS[3:2]) begin
          for (int b = 0; b < 4; b++) begin
            if (io_be[b]) begin
              ptr_ff[8*b +: 8] <= io_wdata[8*b +: 8];
            end
          end
          ptr_ff[1:0] <= 2'h0;
        end
      end

      // Transfer sequencer
      always_comb begin
        case (st_ff)
          ibm_pkg::IBM_IDLE: nxt_st = start_up ? ibm_pkg::IBM_XFER : ibm_pkg::IBM_IDLE;
          ibm_pkg::IBM_XFER: begin
            if (stop) begin
              nxt_st = ibm_pkg::IBM_IDLE;
            end else if (drv_done[ch] && !f_out_vld) begin
              nxt_st = ibm_pkg::IBM_DONE;
            end else begin
              nxt_st = ibm_pkg::IBM_XFER;
            end
          end
          ibm_pkg::IBM_DONE: nxt_st = stop ? ibm_pkg::IBM_IDLE : ibm_pkg::IBM_DONE;
          default:           nxt_st = ibm_pkg::IBM_IDLE;
        endcase
      end

      always_ff @(posedge mclk) begin
        if (rst) begin
          st_ff <= ibm_pkg::IBM_IDLE;
        end else if (ce) begin
          st_ff <= nxt_st;
        end
      end

      // Status: events win over write-one clears
      always_ff @(posedge mclk) begin
        if (rst) begin
          stat_ff  <= 8'h0;
          irq_d_ff <= 1'b0;
        end else if (ce) begin
          irq_d_ff <= drv_irq[ch];
          stat_ff[ibm_pkg::ST_ACT_BIT] <= (nxt_st == ibm_pkg::IBM_XFER);
          if (drv_irq[ch] && !irq_d_ff) begin
            stat_ff[ibm_pkg::ST_INT_BIT] <= 1'b1;
          end else if (wr_st && io_wdata[16+ibm_pkg::ST_INT_BIT]) begin
            stat_ff[ibm_pkg::ST_INT_BIT] <= 1'b0;
          end
          if (mem_err[ch] && st_ff == ibm_pkg::IBM_XFER) begin
            stat_ff[ibm_pkg::ST_ERR_BIT] <= 1'b1;
          end else if (wr_st && io_wdata[16+ibm_pkg::ST_ERR_BIT]) begin
            stat_ff[ibm_pkg::ST_ERR_BIT] <= 1'b0;
          end
          if (wr_st) begin
            stat_ff[6:5] <= io_wdata[22:21];
          end
        end
      end

      // Buffer is flushed on stop so a restart begins afresh
      ibm_fifo #(
        .WIDTH (DWIDTH),
        .DEPTH (DEPTH)
      ) u_fifo (
        .mclk      (mclk),
        .rst       (rst),
        .ce        (ce),
        .flush     (stop || start_up),
        .in_valid  (drv_valid[ch] && drv_ready_ff[ch] && st_ff == ibm_pkg::IBM_XFER),
        .in_ready  (f_in_rdy),
        .in_data   (drv_data[ch*DWIDTH +: DWIDTH]),
        .out_valid (f_out_vld),
        .out_ready (mem_ready[ch] || !mem_valid_ff[ch]),
        .out_data  (f_out_data)
      );

      always_ff @(posedge mclk) begin
        if (rst || (ce && (stop || start_up))) begin
          mem_valid_ff[ch]                 <= 1'b0;
          mem_data_ff[ch*DWIDTH +: DWIDTH] <= '0;
          drv_ready_ff[ch]                 <= 1'b0;
        end else if (ce) begin
          // Ready every other cycle, so a registered ready never promises a full buffer
          drv_ready_ff[ch] <= f_in_rdy && !drv_ready_ff[ch] && (nxt_st == ibm_pkg::IBM_XFER);
          if (mem_ready[ch] || !mem_valid_ff[ch]) begin
            mem_valid_ff[ch]                 <= f_out_vld && cmd_ff[ibm_pkg::CMD_START_BIT];
            mem_data_ff[ch*DWIDTH +: DWIDTH] <= f_out_data;
          end
        end
      end

      always_ff @(posedge mclk) begin
        if (rst) begin
          bm_dir_ff[ch]          <= 1'b0;
          bm_run_ff[ch]          <= 1'b0;
          bm_abort_ff[ch]        <= 1'b0;
          table_ptr_ff[32*ch +: 32] <= 32'h0;
        end else if (ce) begin
          bm_dir_ff[ch]          <= cmd_ff[ibm_pkg::CMD_DIR_BIT];
          bm_run_ff[ch]          <= (nxt_st == ibm_pkg::IBM_XFER);
          bm_abort_ff[ch]        <= stop && st_ff == ibm_pkg::IBM_XFER;
          table_ptr_ff[32*ch +: 32] <= ptr_ff;
        end
      end

      assign bm_word[ch] = (bm_ofs[2]) ? ptr_ff : {8'h0, stat_ff, 8'h0, cmd_ff};
    end
  endgenerate

  always_comb begin
    nxt_io_rdata = 32'h0;
    if (bm_hit) begin
      nxt_io_rdata = bm_word[bm_ofs[3]];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      io_rdata_ff <= 32'h0;
    end else if (ce && io_rd) begin
      io_rdata_ff <= nxt_io_rdata;
    end
  end
endmodule

// File: ibm_pkg.sv
// Purpose: Constants shared by the IDE bus master decode and control block
// Assumes: Byte-addressed I/O and configuration accesses, 32-bit data
// Notes:   Offsets are byte offsets inside their spaces
package ibm_pkg;
  localparam logic [3:0]  OFS_PRI_CMD   = 4'h0;
  localparam logic [3:0]  OFS_PRI_STAT  = 4'h2;
  localparam logic [3:0]  OFS_PRI_PTR   = 4'h4;
  localparam logic [3:0]  OFS_SEC_CMD   = 4'h8;
  localparam logic [3:0]  OFS_SEC_STAT  = 4'ha;
  localparam logic [3:0]  OFS_SEC_PTR   = 4'hc;
  localparam logic [7:0]  CFG_PROG_IF   = 8'h09;
  localparam logic [7:0]  CFG_PRI_CBASE = 8'h10;
  localparam logic [7:0]  CFG_PRI_CTRL  = 8'h14;
  localparam logic [7:0]  CFG_SEC_CBASE = 8'h18;
  localparam logic [7:0]  CFG_SEC_CTRL  = 8'h1c;
  localparam logic [7:0]  CFG_BM_BASE   = 8'h20;
  localparam logic [15:0] PRI_CMD_LO    = 16'h01f0;
  localparam logic [15:0] PRI_CTL_ADR   = 16'h03f6;
  localparam logic [15:0] SEC_CMD_LO    = 16'h0170;
  localparam logic [15:0] SEC_CTL_ADR   = 16'h0376;
  localparam logic [7:0]  CMD_RESET     = 8'h00;
  localparam logic [7:0]  PROG_IF_RESET = 8'hba;
  localparam int          CMD_START_BIT = 0;
  localparam int          CMD_DIR_BIT   = 3;
  localparam int          ST_ACT_BIT    = 0;
  localparam int          ST_ERR_BIT    = 1;
  localparam int          ST_INT_BIT    = 2;
  localparam int          PI_BM_BIT     = 7;
  localparam int          PI_RPT_BIT    = 6;
  localparam int          PI_PEN_BIT    = 5;
  localparam int          PI_SEN_BIT    = 4;
  localparam int          PI_SNAT_BIT   = 2;
  localparam int          PI_PNAT_BIT   = 0;
  localparam int          FIFO_DEPTH    = 16;
  localparam int          FIFO_WIDTH    = 32;
  typedef enum logic [2:0] {
    IBM_IDLE = 3'b001,
    IBM_XFER = 3'b010,
    IBM_DONE = 3'b100
  } ibm_state_t;
endpackage

// File: ibm_fifo.sv
// Purpose: Data buffer with valid/ready handshake on both sides
// Assumes: Single clock, synchronous reset
// Notes:   flush empties the buffer at once
`timescale 1ns/1ps
module ibm_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wp_ff;
  logic [AW-1:0]    rp_ff;
  logic [AW:0]      cnt_ff;
  logic             push;
  logic             pop;
  assign in_ready  = (cnt_ff != (AW+1)'(DEPTH));
  assign out_valid = (cnt_ff != '0);
  assign out_data  = mem_ff[rp_ff];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  always_ff @(posedge mclk) begin
    if (ce && push) begin
      mem_ff[wp_ff] <= in_data;
    end
  end
  always_ff @(posedge mclk) begin
    if (rst || (ce && flush)) begin
      wp_ff  <= '0;
      rp_ff  <= '0;
      cnt_ff <= '0;
    end else if (ce) begin
      if (push) begin
        wp_ff <= (wp_ff == AW'(DEPTH-1)) ? '0 : wp_ff + 1'b1;
      end
      if (pop) begin
        rp_ff <= (rp_ff == AW'(DEPTH-1)) ? '0 : rp_ff + 1'b1;
      end
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// File: ibm_ctrl_sva.sv
// Purpose: Port-level assertions for the IDE bus master control block
// Assumes: Single clock domain, synchronous active-high reset
// Notes:   Bound to ibm_ctrl from the bench top file
`timescale 1ns/1ps
module ibm_ctrl_sva #(
  parameter int DWIDTH = 32
) (
  input wire logic                mclk,
  input wire logic                rst,
  input wire logic                ce,
  input wire logic                io_wr,
  input wire logic                io_rd,
  input wire logic [3:0]          io_be,
  input wire logic [31:0]         io_wdata,
  input wire logic                io_hit_ff,
  input wire logic [1:0]          drv_sel_ff,
  input wire logic [1:0]          drv_ctl_sel_ff,
  input wire logic [1:0]          drv_ready_ff,
  input wire logic [1:0]          mem_valid_ff,
  input wire logic [1:0]          mem_ready,
  input wire logic [2*DWIDTH-1:0] mem_data_ff,
  input wire logic [1:0]          bm_run_ff,
  input wire logic [1:0]          bm_abort_ff
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  hit_cause_a: assert property (io_hit_ff |-> $past(ce && (io_rd || io_wr)))
    else $error("claim without an access");
  pri_sel_a: assert property ((drv_sel_ff[0] || drv_ctl_sel_ff[0]) |-> io_hit_ff)
    else $error("primary drive select without claim");
  sec_sel_a: assert property ((drv_sel_ff[1] || drv_ctl_sel_ff[1])
    |-> io_hit_ff && !drv_sel_ff[0] && !drv_ctl_sel_ff[0])
    else $error("secondary select overlaps or unclaimed");
  pri_start_a: assert property ($rose(bm_run_ff[0]) |-> $past(io_wr && io_be[0] && io_wdata[0]))
    else $error("primary run without start write");
  sec_start_a: assert property ($rose(bm_run_ff[1]) |-> $past(io_wr && io_be[0] && io_wdata[0]))
    else $error("secondary run without start write");
  abort_pulse_a: assert property (bm_abort_ff[0]
    |-> !bm_run_ff[0] && $past(bm_run_ff[0]) ##1 !bm_abort_ff[0])
    else $error("abort pulse wrong");
  idle_block_a: assert property (!bm_run_ff[0] [*2] |-> !drv_ready_ff[0])
    else $error("drive data taken while stopped");
  stall_hold_a: assert property (mem_valid_ff[0] && !mem_ready[0] && bm_run_ff[0]
    |=> !bm_run_ff[0] || (mem_valid_ff[0] && $stable(mem_data_ff[31:0])))
    else $error("memory word changed while stalled");
  chan_apart_a: assert property (bm_abort_ff[0] |-> $stable(bm_run_ff[1]))
    else $error("secondary run disturbed by primary stop");
endmodule

// File: ibm_drive_model.sv
// Purpose: Behavioural drive and memory stand-in for one channel
// Assumes: Words are offered only while the channel runs
// Notes:   Data lines show the inverse of the last word when idle
`timescale 1ns/1ps
module ibm_drive_model (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        run,
  input  wire logic        stall,
  input  wire logic [7:0]  n_words,
  input  wire logic [31:0] base,
  input  wire logic        drv_ready,
  output logic             drv_valid_ff,
  output logic      [31:0] drv_data,
  output logic             drv_done_ff,
  output logic             drv_irq_ff,
  output logic             mem_ready
);
  logic [7:0]  cnt_ff = 8'h00;
  logic [31:0] word_ff = 32'h0;
  // Hold each word until taken; a stop restarts the count
  always_ff @(posedge mclk) begin
    if (rst || !run) begin
      cnt_ff       <= 8'h00;
      drv_valid_ff <= 1'b0;
    end else if (!drv_valid_ff || drv_ready) begin
      drv_valid_ff <= (cnt_ff < n_words);
      if (cnt_ff < n_words) begin
        word_ff <= base + {24'h0, cnt_ff};
        cnt_ff  <= cnt_ff + 8'h01;
      end
    end
  end
  always_ff @(posedge mclk) begin
    drv_done_ff <= run && !rst && (cnt_ff == n_words) && !drv_valid_ff;
    drv_irq_ff  <= run && !rst && (cnt_ff == n_words) && !drv_valid_ff;
  end
  assign drv_data  = drv_valid_ff ? word_ff : ~word_ff;
  assign mem_ready = !stall;
endmodule

// File: ide_busmaster_decode_ctrl_bench.sv
// Purpose: Self-checking bench for the IDE bus master control block
// Assumes: Inputs change at the falling edge
// Notes:   Read results are noted in a queue and checked by a watcher
`timescale 1ns/1ps
module ide_busmaster_decode_ctrl_bench;
  typedef struct {string n; logic c; logic [31:0] v; logic [31:0] m; logic [4:0] s;} ibm_note_t;
  logic        mclk = 1'b0, rst = 1'b1, cfg_wr = 1'b0, cfg_rd = 1'b0, io_wr = 1'b0, io_rd = 1'b0;
  logic [7:0]  cfg_addr = 8'h00, n_words = 8'h00;
  logic [15:0] io_addr = 16'h0;
  logic [3:0]  cfg_be = 4'h0, io_be = 4'h0;
  logic [31:0] cfg_wdata = 32'h0, io_wdata = 32'h0, r, base [2];
  logic [1:0]  mem_err = 2'b00, stall = 2'b00;
  wire  [63:0] drv_data, mem_data_ff, table_ptr_ff;
  wire  [31:0] cfg_rdata_ff, io_rdata_ff;
  wire         io_hit_ff;
  wire  [1:0]  drv_sel_ff, drv_ctl_sel_ff, drv_irq, drv_done, drv_valid, drv_ready_ff;
  wire  [1:0]  mem_valid_ff, mem_ready, bm_dir_ff, bm_run_ff, bm_abort_ff;
  int          mismatches = 0, tests_run = 0, got [2] = '{0, 0};
  bit          pend = 1'b0;
  ibm_note_t   q [$], e;
  logic [15:0] da [18] = '{16'h01f0, 16'h01f7, 16'h03f6, 16'h0170, 16'h0376, 16'h01f8,
                           16'h0440, 16'h0447, 16'h0448, 16'h0452, 16'h0170, 16'h01f0,
                           16'h0400, 16'h0407, 16'h0412, 16'h0447, 16'h01f0, 16'h03f7};
  logic [4:0]  ds [18] = '{5'h11, 5'h11, 5'h14, 5'h12, 5'h18, 5'h00, 5'h12, 5'h12, 5'h00,
                           5'h18, 5'h00, 5'h00, 5'h11, 5'h11, 5'h14, 5'h00, 5'h00, 5'h00};
  logic [7:0]  pv [3] = '{8'h30, 8'h15, 8'h25};
  logic [7:0]  pe [3] = '{8'hba, 8'h9f, 8'haf};
  logic [31:0] bv [4] = '{32'h0401, 32'h0411, 32'h0441, 32'h0451};

  always #50 mclk = ~mclk;

  ibm_ctrl ibm_ctrl_i (
    .mclk(mclk), .rst(rst), .ce(1'b1), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
    .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata_ff(cfg_rdata_ff), .io_wr(io_wr),
    .io_rd(io_rd), .io_addr(io_addr), .io_be(io_be), .io_wdata(io_wdata),
    .io_rdata_ff(io_rdata_ff), .io_hit_ff(io_hit_ff), .drv_sel_ff(drv_sel_ff),
    .drv_ctl_sel_ff(drv_ctl_sel_ff), .drv_irq(drv_irq), .drv_done(drv_done), .mem_err(mem_err),
    .drv_valid(drv_valid), .drv_ready_ff(drv_ready_ff), .drv_data(drv_data),
    .mem_valid_ff(mem_valid_ff), .mem_ready(mem_ready), .mem_data_ff(mem_data_ff),
    .bm_dir_ff(bm_dir_ff), .bm_run_ff(bm_run_ff), .bm_abort_ff(bm_abort_ff),
    .table_ptr_ff(table_ptr_ff));

  for (genvar g = 0; g < 2; g++) begin : ch
    ibm_drive_model ibm_drive_model_i (
      .mclk(mclk), .rst(rst), .run(bm_run_ff[g]), .stall(stall[g]), .n_words(n_words),
      .base(base[g]), .drv_ready(drv_ready_ff[g]), .drv_valid_ff(drv_valid[g]),
      .drv_data(drv_data[g*32+:32]), .drv_done_ff(drv_done[g]), .drv_irq_ff(drv_irq[g]),
      .mem_ready(mem_ready[g]));
  end

  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic acc(input logic c, input logic w, input logic [15:0] a, input logic [3:0] be,
                     input logic [31:0] d, input logic [31:0] m, input logic [4:0] s,
                     input string n);
    if (!(c && w)) q.push_back('{n, c, d, m, s});
    cfg_wr = c & w;
    cfg_rd = c & ~w;
    io_wr = ~c & w;
    io_rd = ~c & ~w;
    cfg_addr = a[7:0];
    io_addr = a;
    cfg_be = be;
    io_be = be;
    cfg_wdata = d;
    io_wdata = d;
    @(negedge mclk);
  endtask

  task automatic drain(input int n);
    {cfg_wr, cfg_rd, io_wr, io_rd} = 4'h0;
    for (int k = 0; k < 800 && (got[0] < n || got[1] < n); k++) begin
      stall = 2'($urandom);
      @(negedge mclk);
    end
    stall = 2'b00;
    chk("words", got[0], n);
  endtask

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Watcher: registered answers are checked at the edge after the request
  always @(posedge mclk) begin
    if (pend) begin
      e = q.pop_front();
      chk(e.n, (e.c ? cfg_rdata_ff : io_rdata_ff) & e.m, e.v & e.m);
      chk(e.n, {27'h0, io_hit_ff, drv_ctl_sel_ff, drv_sel_ff}, {27'h0, e.s});
    end
    pend = !rst && (io_rd || io_wr || cfg_rd);
    for (int c = 0; c < 2; c++) begin
      if (mem_valid_ff[c] && mem_ready[c]) begin
        chk("mem_data", mem_data_ff[c*32+:32], base[c] + got[c]);
        got[c]++;
      end
    end
  end

  initial begin
    repeat (5000) @(posedge mclk);
    mismatches++;
    close_out();
  end

  initial begin
    void'($urandom(32'ha3c4));
    repeat (20) @(negedge mclk);
    rst = 1'b0;
    for (int i = 0; i < 4; i++) acc(1, 1, 16'h10 + 16'(4 * i), 4'hf, bv[i], 0, 0, "");
    for (int p = 0; p < 3; p++) begin
      acc(1, 1, 16'h08, 4'h2, {16'h0, pv[p], 8'h0}, 0, 0, "");
      acc(1, 0, 16'h08, 4'h2, {16'h0, pe[p], 8'h0}, 32'hff00, 0, "prog_if");
      for (int i = 0; i < 6; i++) acc(0, 0, da[p*6+i], 4'h1, 0, 0, ds[p*6+i], "decode");
    end
    acc(1, 1, 16'h08, 4'h2, 32'h3000, 0, 0, "");
    acc(1, 0, 16'h08, 4'h2, 32'hba00, 32'hff00, 0, "prog_if");
    $display("test decode done");
    acc(1, 1, 16'h20, 4'hf, 32'hc001, 0, 0, "");
    acc(0, 0, 16'hc000, 4'hf, 0, 32'h0007_00ff, 5'h10, "pri_reset");
    acc(0, 0, 16'hc008, 4'hf, 0, 32'h0007_00ff, 5'h10, "sec_reset");
    r = $urandom;
    acc(0, 1, 16'hc004, 4'hf, r, 0, 5'h10, "ptr_wr");
    acc(0, 1, 16'hc00c, 4'hf, ~r, 0, 5'h10, "ptr_wr");
    acc(0, 1, 16'hc004, 4'h8, 32'h5a00_0000, 0, 5'h10, "ptr_byte");
    acc(0, 0, 16'hc004, 4'hf, {8'h5a, r[23:2], 2'b00}, '1, 5'h10, "pri_ptr");
    acc(0, 0, 16'hc00c, 4'hf, ~r & 32'hffff_fffc, '1, 5'h10, "sec_ptr");
    chk("table_ptr", table_ptr_ff[31:0], {8'h5a, r[23:2], 2'b00});
    acc(0, 1, 16'hc000, 4'h1, 32'h08, 0, 5'h10, "dir_wr");
    acc(0, 0, 16'hc000, 4'h1, 32'h08, 32'hff, 5'h10, "dir_rd");
    chk("dir", {30'h0, bm_dir_ff}, 32'h1);
    $display("test registers done");
    n_words = 8'd20;
    stall = 2'b11;
    base[0] = $urandom;
    base[1] = $urandom;
    acc(0, 1, 16'hc000, 4'h1, 32'h09, 0, 5'h10, "pri_go");
    acc(0, 1, 16'hc008, 4'h1, 32'h01, 0, 5'h10, "sec_go");
    acc(0, 0, 16'hc000, 4'h5, 32'h0001_0009, 32'h0001_00ff, 5'h10, "act_set");
    {cfg_wr, cfg_rd, io_wr, io_rd} = 4'h0;
    repeat (60) @(negedge mclk);
    chk("run", {30'h0, bm_run_ff}, 32'h3);
    chk("full", {30'h0, drv_ready_ff}, 32'h0);
    drain(20);
    repeat (4) @(negedge mclk);
    acc(0, 0, 16'hc000, 4'h5, 32'h0004_0009, 32'h0007_00ff, 5'h10, "done");
    acc(0, 1, 16'hc000, 4'h4, 32'h0004_0000, 0, 5'h10, "int_clr");
    acc(0, 0, 16'hc000, 4'h5, 32'h0000_0009, 32'h0007_00ff, 5'h10, "int_rd");
    acc(0, 0, 16'hc008, 4'h5, 32'h0004_0001, 32'h0007_00ff, 5'h10, "sec_done");
    acc(0, 1, 16'hc000, 4'h1, 32'h08, 0, 5'h10, "pri_stop");
    acc(0, 1, 16'hc008, 4'h1, 32'h00, 0, 5'h10, "sec_stop");
    $display("test transfer done");
    stall = 2'b01;
    got[0] = 0;
    base[0] = $urandom;
    acc(0, 1, 16'hc000, 4'h1, 32'h09, 0, 5'h10, "pri_go");
    {cfg_wr, cfg_rd, io_wr, io_rd} = 4'h0;
    repeat (10) @(negedge mclk);
    mem_err = 2'b01;
    @(negedge mclk);
    mem_err = 2'b00;
    acc(0, 0, 16'hc000, 4'h5, 32'h0003_0009, 32'h0007_00ff, 5'h10, "err_set");
    acc(0, 1, 16'hc000, 4'h1, 32'h08, 0, 5'h10, "abort");
    chk("abort", {28'h0, bm_abort_ff, bm_run_ff}, 32'h4);
    {cfg_wr, cfg_rd, io_wr, io_rd} = 4'h0;
    repeat (2) @(negedge mclk);
    chk("flushed", {31'h0, mem_valid_ff[0]}, 32'h0);
    acc(0, 0, 16'hc000, 4'h5, 32'h0002_0008, 32'h0003_00ff, 5'h10, "act_clr");
    acc(0, 1, 16'hc000, 4'h4, 32'h0002_0000, 0, 5'h10, "err_clr");
    got[0] = 0;
    got[1] = 20;
    acc(0, 1, 16'hc000, 4'h1, 32'h09, 0, 5'h10, "restart");
    drain(20);
    acc(0, 0, 16'hc000, 4'h5, 32'h0000_0009, 32'h0003_00ff, 5'h10, "err_rd");
    {cfg_wr, cfg_rd, io_wr, io_rd} = 4'h0;
    $display("test abort done");
    close_out();
  end
endmodule

bind ibm_ctrl ibm_ctrl_sva #(.DWIDTH(DWIDTH)) ibm_ctrl_sva_i (
  .mclk(mclk), .rst(rst), .ce(ce), .io_wr(io_wr), .io_rd(io_rd), .io_be(io_be),
  .io_wdata(io_wdata), .io_hit_ff(io_hit_ff), .drv_sel_ff(drv_sel_ff),
  .drv_ctl_sel_ff(drv_ctl_sel_ff), .drv_ready_ff(drv_ready_ff), .mem_valid_ff(mem_valid_ff),
  .mem_ready(mem_ready), .mem_data_ff(mem_data_ff), .bm_run_ff(bm_run_ff),
  .bm_abort_ff(bm_abort_ff));
